// ===== src/ils_pkg.sv
// Constants for the interrupt aggregator and line-interface serial port.
// Assumes a synchronous register port on the core clock.
// What this block does
// [RULE1] One shared open-drain active-low request pin
// [RULE2] Events latch until the host reads them
// [RULE3] Enabled latched events set framer summary bits
// [RULE4] Framer summary gated by master enable bit
// [RULE5] Serial done gated by serial interrupt enable
// [RULE6] Pin asserted while any source active
// [RULE7] Host reads master, summary, then event registers
// [RULE8] Serial port writes or reads one byte
// [RULE9] Two independent chip selects on octal variant
// [RULE10] Sixteen-bit transfer: command byte then data
// [RULE11] Command byte holds address and read flag
// [RULE12] Read stores eight received bits in data
// [RULE13] Writing command register starts a transfer
// [RULE14] Write data follows command on eight clocks
// [RULE15] Read data sampled on eight following clocks
// [RULE16] Select held whole transfer, then done set
// [RULE17] MSB first; done clears on read or start
package ils_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          LOCAL_W         = 9;
  localparam logic [8:0]  MASTER_SUM_OFS  = 9'h01d;
  localparam logic [8:0]  MASTER_EN_OFS   = 9'h01e;
  localparam logic [8:0]  SER_CMD_OFS     = 9'h022;
  localparam logic [8:0]  SER_DATA_OFS    = 9'h023;
  localparam logic [8:0]  LINK_STAT_OFS   = 9'h024;
  localparam logic [8:0]  SER_CFG_OFS     = 9'h025;
  localparam logic [8:0]  EVT_LATCH_OFS   = 9'h040;
  localparam logic [8:0]  EVT_ENABLE_OFS  = 9'h048;
  localparam logic [8:0]  FRAMER_SUM_OFS  = 9'h050;
  localparam int          EVT_REGS        = 8;
  localparam int          CMD_READ_BIT    = 7;
  localparam int          STAT_DONE_BIT   = 0;
  localparam int          STAT_BUSY_BIT   = 1;
  localparam int          STAT_FULL_BIT   = 2;
  localparam int          CFG_IRQ_EN_BIT  = 0;
  localparam int          CFG_SEL2_BIT    = 1;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam int          XFER_BITS       = 16;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          SCLK_HALF_NS    = 200;
  localparam int          SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CMD_FIFO_DEPTH  = 8;
  typedef enum logic [0:0] {ILS_IDLE, ILS_SHIFT} ils_state_e;
endpackage

// ===== src/ils_top.sv
// Interrupt aggregation and serial control port toward a line interface.
// Assumes register strobes and event pulses are on i_clock; serial input is a pin.
`timescale 1ns/1ps

module ils_fifo #(
  parameter int W = 17,
  parameter int D = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rstn,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two");
  end

  // Full and empty from pointer wrap bit
  assign o_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign o_valid = (wr_q != rd_q);
  assign o_data  = mem_q[rd_q[AW-1:0]];

  // Storage write
  always_ff @(posedge i_clock) begin
    if (i_valid && o_ready) begin
      mem_q[wr_q[AW-1:0]] <= i_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (i_valid && o_ready) wr_q <= wr_q + 1'b1;
      if (o_valid && i_ready) rd_q <= rd_q + 1'b1;
    end
  end
endmodule // ils_fifo

module ils_top #(
  parameter int NFRAMER = 8,
  parameter int NUM_CS  = 2
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_rstn,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [ils_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic [7:0]                  i_reg_wdata,
  output logic [7:0]                       o_reg_rdata,
  input  wire logic [NFRAMER*64-1:0]       i_event,
  output logic                             o_shared_irq_n,
  output logic                             o_shared_irq_n_oe,
  output logic                             o_cmd_ready,
  output logic                             o_liu_serial_clock,
  output logic                             o_liu_data_out,
  input  wire logic                        i_liu_data_in,
  output logic                             o_liu_select_first_n,
  output logic                             o_liu_select_second_n
);
  import ils_pkg::*;

  localparam int FW = (NFRAMER > 1) ? $clog2(NFRAMER) : 1;

  if (NFRAMER < 1 || NFRAMER > 8 || NUM_CS < 1 || NUM_CS > 2) begin : g_chk
    $error("NFRAMER must be 1..8 and NUM_CS 1..2");
  end

  logic [LOCAL_W-1:0] loc;
  logic [2:0]         fsel;
  logic [7:0]         evt_q [NFRAMER][EVT_REGS];
  logic [7:0]         ien_q [NFRAMER][EVT_REGS];
  logic [7:0]         fsum  [NFRAMER];
  logic [7:0]         master_en_q;
  logic [7:0]         master_sum;
  logic [7:0]         sdat_q;
  logic [7:0]         scfg_q;
  logic               done_q;
  logic               sreq;
  logic               irq_q;
  logic [7:0]         rdata_d;
  logic               fifo_in_rdy;
  logic               fifo_valid;
  logic [16:0]        fifo_out;
  logic               pop;
  logic               fin;
  ils_state_e         state_q;
  logic [7:0]         div_q;
  logic               sclk_q;
  logic [4:0]         bits_q;
  logic [15:0]        sh_q;
  logic [7:0]         rx_q;
  logic               rdop_q;
  logic               sel2_q;
  logic               cs1_n_q;
  logic               cs2_n_q;
  logic               din_m_q;
  logic               din_s_q;

  assign loc  = i_reg_addr[LOCAL_W-1:0];
  assign fsel = i_reg_addr[ADDR_W-1:LOCAL_W];

  // Per framer event latches, enables and summary
  for (genvar f = 0; f < NFRAMER; f++) begin : g_fr
    for (genvar r = 0; r < EVT_REGS; r++) begin : g_rg
      logic hit;
      assign hit = (fsel == 3'(f)) && (loc == EVT_LATCH_OFS + 9'(r));
      // Latch events; a new event beats the read clear
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          evt_q[f][r] <= REG_RESET;
        end else begin
          evt_q[f][r] <= (evt_q[f][r] & ~{8{i_reg_rd && hit}})
                         | i_event[(f*EVT_REGS+r)*8 +: 8]; // [RULE2]
        end
      end
      // Enable register write
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          ien_q[f][r] <= REG_RESET;
        end else if (i_reg_wr && fsel == 3'(f) && loc == EVT_ENABLE_OFS + 9'(r)) begin
          ien_q[f][r] <= i_reg_wdata;
        end
      end
      assign fsum[f][r] = |(evt_q[f][r] & ien_q[f][r]); // [RULE3]
    end
    assign master_sum[f] = (|fsum[f]) & master_en_q[f]; // [RULE4]
  end
  for (genvar u = NFRAMER; u < 8; u++) begin : g_pad
    assign master_sum[u] = 1'b0;
  end

  // Serial request and shared pin
  assign sreq = done_q & scfg_q[CFG_IRQ_EN_BIT]; // [RULE5]
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) irq_q <= 1'b0;
    else         irq_q <= (|master_sum) | sreq; // [RULE6]
  end
  assign o_shared_irq_n    = 1'b0; // [RULE1]
  assign o_shared_irq_n_oe = irq_q; // [RULE1]

  // Global register writes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      master_en_q <= REG_RESET;
      scfg_q      <= REG_RESET;
    end else if (i_reg_wr) begin
      if (loc == MASTER_EN_OFS) master_en_q <= i_reg_wdata;
      if (loc == SER_CFG_OFS)   scfg_q <= i_reg_wdata;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 8'h00;
    unique case (loc)
      MASTER_SUM_OFS: rdata_d = master_sum;
      MASTER_EN_OFS:  rdata_d = master_en_q;
      SER_DATA_OFS:   rdata_d = sdat_q;
      SER_CFG_OFS:    rdata_d = scfg_q;
      LINK_STAT_OFS:  rdata_d = {5'h00, !fifo_in_rdy, state_q == ILS_SHIFT, done_q};
      FRAMER_SUM_OFS: if (32'(fsel) < NFRAMER) rdata_d = fsum[fsel[FW-1:0]];
      default: begin
        if (32'(fsel) < NFRAMER && loc >= EVT_LATCH_OFS && loc < FRAMER_SUM_OFS) begin
          if (loc < EVT_ENABLE_OFS) rdata_d = evt_q[fsel[FW-1:0]][loc[2:0]];
          else                      rdata_d = ien_q[fsel[FW-1:0]][loc[2:0]];
        end
      end
    endcase
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)       o_reg_rdata <= 8'h00;
    else if (i_reg_rd) o_reg_rdata <= rdata_d;
  end

  // Command queue; a command write pushes select, command and data
  ils_fifo #(.W(17), .D(CMD_FIFO_DEPTH)) u_cmd (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_valid (i_reg_wr && loc == SER_CMD_OFS), // [RULE13]
    .o_ready (fifo_in_rdy),
    .i_data  ({scfg_q[CFG_SEL2_BIT], i_reg_wdata,
               i_reg_wdata[CMD_READ_BIT] ? 8'h00 : sdat_q}), // [RULE11] [RULE10]
    .o_valid (fifo_valid),
    .i_ready (state_q == ILS_IDLE),
    .o_data  (fifo_out)
  );
  assign o_cmd_ready = fifo_in_rdy;
  assign pop = fifo_valid && state_q == ILS_IDLE;
  assign fin = state_q == ILS_SHIFT && div_q == 8'(SCLK_HALF_CYC - 1)
               && sclk_q && bits_q == 5'(XFER_BITS);

  // Serial input synchroniser
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else begin
      din_m_q <= i_liu_data_in;
      din_s_q <= din_m_q;
    end
  end

  // Serial engine: clock divider, shifter, selects
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ILS_IDLE;
      div_q   <= 8'h00;
      sclk_q  <= 1'b0;
      bits_q  <= 5'h00;
      sh_q    <= 16'h0000;
      rx_q    <= 8'h00;
      rdop_q  <= 1'b0;
      sel2_q  <= 1'b0;
      cs1_n_q <= 1'b1;
      cs2_n_q <= 1'b1;
    end else if (pop) begin
      state_q <= ILS_SHIFT;
      div_q   <= 8'h00;
      sclk_q  <= 1'b0;
      bits_q  <= 5'h00;
      sh_q    <= fifo_out[15:0]; // [RULE8]
      rdop_q  <= fifo_out[8+CMD_READ_BIT];
      sel2_q  <= fifo_out[16] && NUM_CS == 2;
      cs1_n_q <= fifo_out[16] && NUM_CS == 2; // [RULE9]
      cs2_n_q <= !(fifo_out[16] && NUM_CS == 2); // [RULE9]
    end else if (state_q == ILS_SHIFT) begin
      if (div_q == 8'(SCLK_HALF_CYC - 1)) begin
        div_q <= 8'h00;
        if (!sclk_q) begin
          sclk_q <= 1'b1;
          bits_q <= bits_q + 5'h01;
          if (bits_q >= 5'd8) rx_q <= {rx_q[6:0], din_s_q}; // [RULE15] [RULE12]
        end else if (fin) begin
          sclk_q  <= 1'b0;
          state_q <= ILS_IDLE;
          sh_q    <= 16'h0000;
          cs1_n_q <= 1'b1; // [RULE16]
          cs2_n_q <= 1'b1; // [RULE16]
        end else begin
          sclk_q <= 1'b0;
          sh_q   <= {sh_q[14:0], 1'b0}; // [RULE17] [RULE14]
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end
  assign o_liu_serial_clock    = sclk_q;
  assign o_liu_data_out        = sh_q[15];
  assign o_liu_select_first_n  = cs1_n_q;
  assign o_liu_select_second_n = cs2_n_q;

  // Serial data register; a finished read overrides a host write
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)                   sdat_q <= REG_RESET;
    else if (fin && rdop_q)        sdat_q <= rx_q; // [RULE12]
    else if (i_reg_wr && loc == SER_DATA_OFS) sdat_q <= i_reg_wdata;
  end

  // Done flag: set wins over status read or new start
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) done_q <= 1'b0;
    else         done_q <= fin | (done_q & !(pop || (i_reg_rd && loc == LINK_STAT_OFS))); // [RULE16] [RULE17]
  end

  // Helper: serial clock rises in the current transfer
  logic [4:0] rise_cnt_q;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)                 rise_cnt_q <= 5'h00;
    else if (pop)                rise_cnt_q <= 5'h00;
    else if ($rose(sclk_q))      rise_cnt_q <= rise_cnt_q + 5'h01;
  end

  AST_OD_LOW: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE1]
    o_shared_irq_n == 1'b0) else $error("irq pin driven high");
  AST_LATCH_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE2]
    $fell(evt_q[0][0][0]) |-> $past(i_reg_rd) && $past(fsel) == 3'h0
      && $past(loc) == EVT_LATCH_OFS) else $error("event lost without read");
  AST_MASKED: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE3]
    ((evt_q[0][0] & ien_q[0][0]) == 8'h00) |-> !fsum[0][0]) else $error("masked event seen");
  AST_MASTER_GATE: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE4]
    !master_en_q[0] |-> !master_sum[0]) else $error("master enable ignored");
  AST_SER_REQ: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE5]
    done_q && scfg_q[CFG_IRQ_EN_BIT] |=> o_shared_irq_n_oe) else $error("serial req missed");
  AST_PIN: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE6]
    o_shared_irq_n_oe == $past((|master_sum) | sreq)) else $error("pin not following sources");
  AST_EVT_PIN: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE3]
    (|(evt_q[0][0] & ien_q[0][0])) && master_en_q[0] |=> o_shared_irq_n_oe)
    else $error("enabled event not on pin");
  AST_ONE_CS: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE9]
    !(!cs1_n_q && !cs2_n_q)) else $error("both selects active");
  AST_LEN: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE10]
    fin |-> rise_cnt_q == 5'(XFER_BITS)) else $error("transfer not 16 clocks");
  AST_START: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE13]
    pop |=> state_q == ILS_SHIFT ##0 (cs1_n_q ^ cs2_n_q)) else $error("no start");
  AST_CS_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE16]
    state_q == ILS_SHIFT |-> !(cs1_n_q && cs2_n_q)) else $error("select dropped");
  AST_DONE_CLR: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE17]
    i_reg_rd && loc == LINK_STAT_OFS && !fin |=> !done_q) else $error("done not cleared");
  AST_SEL_ROUTE: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE9]
    state_q == ILS_SHIFT |-> cs1_n_q == sel2_q && cs2_n_q == !sel2_q)
    else $error("wrong select driven");

  COV_WRITE: cover property (@(posedge i_clock) disable iff (!i_rstn) fin && !rdop_q);
  COV_READ: cover property (@(posedge i_clock) disable iff (!i_rstn) fin && rdop_q);
  COV_IRQ: cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(o_shared_irq_n_oe));
  COV_FULL: cover property (@(posedge i_clock) disable iff (!i_rstn) !fifo_in_rdy);
endmodule // ils_top

// ===== tb/ils_liu_model.sv
// Behavioural serial slave standing in for the attached line interface.
// Assumes an idle-low serial clock and active-low selects driven by the device.
`timescale 1ns/1ps

module ils_liu_model (
  input  wire logic       i_sclk,
  input  wire logic       i_sdi,
  input  wire logic       i_cs_n,
  input  wire logic [7:0] i_reply,
  output logic            o_sdo
);
  logic [15:0] rx_q   = 16'h0000;
  int          nbits_q = 0;
  int          xfers  = 0;
  logic [15:0] word   = 16'h0000;

  initial o_sdo = 1'b0;

  // Shift in on rising clock while selected, MSB first
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      rx_q    <= {rx_q[14:0], i_sdi};
      nbits_q <= nbits_q + 1;
    end
  end

  // Reply bits change on falling clock after a read command byte
  always @(negedge i_sclk) begin
    // Read flag is the first bit received, now nbits_q - 1 places up
    if (!i_cs_n && nbits_q >= 8 && nbits_q < 16 && rx_q[nbits_q - 1]) begin
      o_sdo <= i_reply[15 - nbits_q];
    end else begin
      o_sdo <= ~o_sdo; // Line not driven: no stale value
    end
  end

  // End of frame keeps a whole word only
  always @(posedge i_cs_n) begin
    if (nbits_q == 16) begin
      word = rx_q;
      xfers++;
    end
    nbits_q <= 0;
    o_sdo   <= ~o_sdo;
  end
endmodule // ils_liu_model

// ===== tb/ils_top_tb.sv
// Self-checking bench for the interrupt aggregator and serial port.
// Assumes the line-interface model file is compiled before this one.
`timescale 1ns/1ps

module ils_top_tb;
  import ils_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [11:0]  reg_addr = 12'h000;
  logic [7:0]   reg_wdata = 8'h00;
  logic [7:0]   reg_rdata;
  logic [511:0] event_v = '0;
  logic         irq_n, irq_oe, cmd_ready, sclk, sdo, sdi, cs1_n, cs2_n;
  logic [7:0]   reply = 8'h00;
  int           err_count = 0;
  int           check_count = 0;
  int           cyc = 0;
  int           f, r, b, en, n0;
  logic [7:0]   c;

  always #25 clock = ~clock;

  ils_top #(.NFRAMER(8), .NUM_CS(2)) dut_u (
    .i_clock(clock), .i_rstn(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_event(event_v), .o_shared_irq_n(irq_n), .o_shared_irq_n_oe(irq_oe),
    .o_cmd_ready(cmd_ready), .o_liu_serial_clock(sclk), .o_liu_data_out(sdo),
    .i_liu_data_in(sdi), .o_liu_select_first_n(cs1_n), .o_liu_select_second_n(cs2_n));

  ils_liu_model liu_u (
    .i_sclk(sclk), .i_sdi(sdo), .i_cs_n(cs1_n & cs2_n), .i_reply(reply), .o_sdo(sdi));

  // Address of a local offset in one framer
  function automatic logic [11:0] ad(input int fr, input logic [8:0] o);
    return {3'(fr), o};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, exp, what);
  endtask

  // One serial transfer with its checks
  task automatic serial(input logic [7:0] cm, input logic [7:0] d, input logic s2,
                        input logic ien);
    int k;
    reply = 8'($urandom);
    n0 = liu_u.xfers;
    wr(ad(0, SER_CFG_OFS), {6'h00, s2, ien});
    wr(ad(0, SER_DATA_OFS), d);
    wr(ad(0, SER_CMD_OFS), cm);
    repeat (3) @(negedge clock);
    chk({6'h00, cs1_n, cs2_n}, {6'h00, s2, !s2}, "select");
    for (k = 0; k < 200 && (cs1_n & cs2_n) !== 1'b1; k++) @(negedge clock);
    repeat (2) @(negedge clock);
    chk(8'(irq_oe), 8'(ien), "serial irq");
    chk(8'(liu_u.xfers - n0), 8'h01, "frame count");
    chk(liu_u.word[15:8], cm, "command byte");
    if (cm[7]) rc(ad(0, SER_DATA_OFS), reply, "read data");
    else chk(liu_u.word[7:0], d, "write data");
    rc(ad(0, LINK_STAT_OFS), 8'h01, "done set");
    rc(ad(0, LINK_STAT_OFS), 8'h00, "done cleared");
    repeat (2) @(negedge clock);
    chk(8'(irq_oe), 8'h00, "irq released");
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    n0 = $urandom(32'h53d5);
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk({3'h0, irq_oe, cs1_n, cs2_n, cmd_ready, sclk}, 8'h0e, "reset pins");
    chk({7'h00, irq_n}, 8'h00, "open drain value");
    rc(ad(0, 9'h1f0), 8'h00, "unmapped");
    $display("test reset done");
    // Events: latch, enable, framer summary, master gating
    for (int i = 0; i < 6; i++) begin
      f = $urandom_range(7);
      r = $urandom_range(7);
      b = $urandom_range(7);
      en = (i < 2) ? i : $urandom_range(1);
      wr(ad(f, EVT_ENABLE_OFS + 9'(r)), 8'(en) << b);
      wr(ad(f, MASTER_EN_OFS), 8'h01 << f);
      rc(ad(f, MASTER_EN_OFS), 8'h01 << f, "master enable");
      event_v[(f * 8 + r) * 8 + b] = 1'b1;
      @(negedge clock);
      event_v = '0;
      repeat (2) @(negedge clock);
      chk(8'(irq_oe), 8'(en), "event irq");
      rc(ad(f, LINK_STAT_OFS), 8'h00, "status first");
      rc(ad(f, MASTER_SUM_OFS), 8'(en) << f, "master summary");
      rc(ad(f, FRAMER_SUM_OFS), 8'(en) << r, "framer summary");
      wr(ad(f, MASTER_EN_OFS), 8'h00);
      rc(ad(f, MASTER_SUM_OFS), 8'h00, "master gated");
      rc(ad(f, EVT_LATCH_OFS + 9'(r)), 8'h01 << b, "latch held");
      rc(ad(f, EVT_LATCH_OFS + 9'(r)), 8'h00, "latch cleared");
      wr(ad(f, EVT_ENABLE_OFS + 9'(r)), 8'h00);
    end
    $display("test events done");
    // Serial: corner cases first, then random
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom);
      serial(c, (i == 0) ? 8'h81 : 8'($urandom), i == 1 || $urandom_range(1), i != 1);
    end
    $display("test serial done");
    // Queue fills, then drains in order
    n0 = liu_u.xfers;
    for (int i = 0; i < 9; i++) wr(ad(0, SER_CMD_OFS), 8'(i));
    chk(8'(cmd_ready), 8'h00, "queue full");
    rc(ad(0, LINK_STAT_OFS), 8'h06, "busy and full");
    for (int i = 0; i < 1500 && liu_u.xfers - n0 < 9; i++) @(negedge clock);
    chk(8'(liu_u.xfers - n0), 8'h09, "queued frames");
    chk(liu_u.word[15:8], 8'h08, "last command");
    $display("test queue done");
    test_done();
  end
endmodule // ils_top_tb
